// ===== core/bswg_top.sv
// Output-mode logic of the bridge steering waveform generator
`timescale 1ns/1ps
`default_nettype none

// Function
// - Full bridge: three outputs static, one modulated
// - Forward 010: a active, d modulated
// - Reverse 011: c active, b modulated
// - Mode bit 0 toggles direction while enabled
// - Direction change waits for next data rise
// - A/C swap, new output modulates after dead band
// - Dead band only on newly modulated output
// - Default polarity: rising data gives rising output
// - Steering routes data to any output subset
// - Steer bit clear holds override level
// - Polarity acts only on steered outputs
// - Shutdown overrides only steered outputs
// - Sync steering updates at data rising edge
// - Override bits act immediately in sync steering
// - Async steering acts at once, may truncate
// - One bit selects dead-band clock source
// - Fast oscillator keeps dead band alive asleep
// - Four-bit select picks one of sixteen sources
// - Independent polarity control per output
// - Dead band counts clock periods up to count
// - Two level fields set shutdown levels b/d, a/c
module bswg_top (
    input wire logic core_clk,                      // 200 MHz system clock
    input wire logic rst_n,                         // Synchronous reset, active low
    input wire logic enable,                        // Unit enable
    input wire logic [2:0] mode,                    // Operating mode field
    input wire logic [3:0] data_input_select,       // Data source select
    input wire logic [15:0] src_in,                 // Asynchronous data sources
    input wire logic [3:0] steer_enable_bits,       // Per-output steering enable
    input wire logic [3:0] override_level_bits,     // Per-output override level
    input wire logic [3:0] output_polarity_bits,    // Per-output polarity, set inverts
    input wire logic shutdown_in,                   // Asynchronous shutdown request, high active
    input wire logic [1:0] shutdown_level_b_d,      // Shutdown level of b and d
    input wire logic [1:0] shutdown_level_a_c,      // Shutdown level of a and c
    input wire logic [5:0] db_rise_count,           // Reverse dead-band count
    input wire logic [5:0] db_fall_count,           // Forward dead-band count
    input wire logic db_clk_select,                 // 1 selects fast oscillator ticks
    input wire logic internal_fast_oscillator,      // Fast oscillator square wave
    input wire logic sleep,                         // System clock halted for dead band
    output logic [3:0] wave_out,                    // Output levels, bit 0 is a
    output logic [3:0] wave_oe,                     // Output enables, high drives
    output logic direction                          // Applied direction, 1 is reverse
);

    default clocking bswg_cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [15:0] src_s1_r, src_s2_r, src_s1_nxt, src_s2_nxt;
    logic sd_s1_r, sd_s2_r, sd_s1_nxt, sd_s2_nxt;
    logic hf_s1_r, hf_s2_r, hf_s3_r, hf_s1_nxt, hf_s2_nxt, hf_s3_nxt;
    logic data_d_r, data_d_nxt;
    logic data_cur, data_rise, db_tick;

    // Two flops on every asynchronous pin; third flop for fast oscillator and selected data edge detection
    always_comb begin
        src_s1_nxt = src_in;
        src_s2_nxt = src_s1_r;
        sd_s1_nxt = shutdown_in;
        sd_s2_nxt = sd_s1_r;
        hf_s1_nxt = internal_fast_oscillator;
        hf_s2_nxt = hf_s1_r;
        hf_s3_nxt = hf_s2_r;
        data_d_nxt = data_cur;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            src_s1_r <= bswg_pkg::SRC_RST;
            src_s2_r <= bswg_pkg::SRC_RST;
            sd_s1_r <= 1'b0;
            sd_s2_r <= 1'b0;
            hf_s1_r <= 1'b0;
            hf_s2_r <= 1'b0;
            hf_s3_r <= 1'b0;
            data_d_r <= 1'b0;
        end else begin
            src_s1_r <= src_s1_nxt;
            src_s2_r <= src_s2_nxt;
            sd_s1_r <= sd_s1_nxt;
            sd_s2_r <= sd_s2_nxt;
            hf_s1_r <= hf_s1_nxt;
            hf_s2_r <= hf_s2_nxt;
            hf_s3_r <= hf_s3_nxt;
            data_d_r <= data_d_nxt;
        end
    end

    // Source pick and edge, dead-band tick source
    always_comb begin
        data_cur = src_s2_r[data_input_select];
        data_rise = data_cur & ~data_d_r;
        // System clock is stopped in sleep, so it yields no ticks then
        db_tick = db_clk_select ? (hf_s2_r & ~hf_s3_r) : ~sleep;
    end

    // ****************************************
    // Full-bridge direction and dead band
    // ****************************************
    bswg_pkg::bswg_fb_state_t fb_st_r, fb_st_nxt;
    logic dir_r, dir_nxt;
    logic [5:0] db_cnt_r, db_cnt_nxt, db_tgt_r, db_tgt_nxt;
    logic fb_mode, rev_req;
    logic [5:0] new_tgt;

    // Reversal is only applied at a data rise; A/C follow dir_nxt with no delay
    always_comb begin
        fb_mode = enable && (mode[2:1] == bswg_pkg::MODE_FB_HI);
        rev_req = data_rise && (mode[0] != dir_r);
        new_tgt = mode[0] ? db_rise_count : db_fall_count;
        fb_st_nxt = fb_st_r;
        dir_nxt = dir_r;
        db_cnt_nxt = db_cnt_r;
        db_tgt_nxt = db_tgt_r;
        if (!fb_mode) begin
            dir_nxt = mode[0];
            fb_st_nxt = bswg_pkg::BSWG_FB_RUN;
            db_cnt_nxt = bswg_pkg::CNT_RST;
        end else if (rev_req) begin
            dir_nxt = mode[0];
            db_tgt_nxt = new_tgt;
            db_cnt_nxt = bswg_pkg::CNT_RST;
            // Zero count means no dead band at all
            fb_st_nxt = (new_tgt != bswg_pkg::CNT_RST) ? bswg_pkg::BSWG_FB_DEAD : bswg_pkg::BSWG_FB_RUN;
        end else begin
            case (fb_st_r)
                bswg_pkg::BSWG_FB_RUN: begin
                    fb_st_nxt = bswg_pkg::BSWG_FB_RUN;
                end
                bswg_pkg::BSWG_FB_DEAD: begin
                    if (db_tick) begin
                        db_cnt_nxt = db_cnt_r + 6'h01;
                        if (db_cnt_nxt == db_tgt_r) begin
                            fb_st_nxt = bswg_pkg::BSWG_FB_RUN;
                        end
                    end
                end
                default: begin
                    fb_st_nxt = bswg_pkg::BSWG_FB_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fb_st_r <= bswg_pkg::BSWG_FB_RUN;
            dir_r <= bswg_pkg::DIR_RST;
            db_cnt_r <= bswg_pkg::CNT_RST;
            db_tgt_r <= bswg_pkg::CNT_RST;
        end else begin
            fb_st_r <= fb_st_nxt;
            dir_r <= dir_nxt;
            db_cnt_r <= db_cnt_nxt;
            db_tgt_r <= db_tgt_nxt;
        end
    end

    // ****************************************
    // Steering selection
    // ****************************************
    logic [3:0] steer_eff_r, steer_eff_nxt;

    // Sync mode latches steering only at a data rise, so no pulse is clipped
    always_comb begin
        steer_eff_nxt = steer_eff_r;
        if (!enable || mode == bswg_pkg::MODE_ASYNC_STEER) begin
            steer_eff_nxt = steer_enable_bits;
        end else if (data_rise) begin
            steer_eff_nxt = steer_enable_bits;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            steer_eff_r <= bswg_pkg::PINS_RST;
        end else begin
            steer_eff_r <= steer_eff_nxt;
        end
    end

    // ****************************************
    // Output stage
    // ****************************************
    // Shutdown level decode; returns {oe, level}
    function automatic logic [1:0] bswg_sd_lvl(input logic [1:0] code, input logic inact);
        case (code)
            bswg_pkg::LVL_INACTIVE: bswg_sd_lvl = {1'b1, inact};
            bswg_pkg::LVL_HIGHZ: bswg_sd_lvl = 2'h0;
            bswg_pkg::LVL_LOW: bswg_sd_lvl = 2'h2;
            default: bswg_sd_lvl = 2'h3;
        endcase
    endfunction

    bswg_pkg::bswg_pins_t pins_r, pins_nxt;
    bswg_pkg::bswg_outcfg_t cfg;
    logic [3:0] fb_pre;
    logic fb_mod;
    logic [1:0] sd_code;
    logic [1:0] sd_val;

    always_comb begin
        cfg = {steer_enable_bits, override_level_bits, output_polarity_bits};
        pins_nxt = '0;
        sd_code = 2'h0;
        sd_val = 2'h0;
        // New side stays inactive until the dead band is over
        fb_mod = data_cur && (fb_st_nxt == bswg_pkg::BSWG_FB_RUN);
        fb_pre[bswg_pkg::IDX_A] = ~dir_nxt;
        fb_pre[bswg_pkg::IDX_B] = dir_nxt & fb_mod;
        fb_pre[bswg_pkg::IDX_C] = dir_nxt;
        fb_pre[bswg_pkg::IDX_D] = ~dir_nxt & fb_mod;
        for (int i = 0; i < bswg_pkg::OUT_NUM; i++) begin
            sd_code = (i == bswg_pkg::IDX_A || i == bswg_pkg::IDX_C) ? shutdown_level_a_c : shutdown_level_b_d;
            sd_val = bswg_sd_lvl(sd_code, cfg.pol[i]);
            if (fb_mode) begin
                pins_nxt.oe[i] = sd_s2_r ? sd_val[1] : 1'b1;
                pins_nxt.lvl[i] = sd_s2_r ? sd_val[0] : (fb_pre[i] ^ cfg.pol[i]);
            end else if (enable && mode[2:1] == bswg_pkg::MODE_STEER_HI) begin
                if (steer_eff_nxt[i]) begin
                    pins_nxt.oe[i] = sd_s2_r ? sd_val[1] : 1'b1;
                    pins_nxt.lvl[i] = sd_s2_r ? sd_val[0] : (data_cur ^ cfg.pol[i]);
                end else begin
                    pins_nxt.oe[i] = 1'b1;
                    pins_nxt.lvl[i] = cfg.ovr[i];
                end
            end
        end
    end

    // Outputs come straight from these flops
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pins_r <= '0;
        end else begin
            pins_r <= pins_nxt;
        end
    end

    assign wave_out = pins_r.lvl;
    assign wave_oe = pins_r.oe;
    assign direction = dir_r;

    // ****************************************
    // Assertions
    // ****************************************
    a_fb_static_ac: assert property ((fb_mode && !sd_s2_r) |=>
        (pins_r.lvl[0] == (!dir_r ^ $past(output_polarity_bits[0])))
        && (pins_r.lvl[2] == (dir_r ^ $past(output_polarity_bits[2]))))
        else $error("full-bridge a/c static levels wrong");
    a_dir_waits_edge: assert property ((fb_mode && !data_rise) |=> (dir_r == $past(dir_r)))
        else $error("direction changed without data rise");
    a_dir_reverses: assert property ((fb_mode && rev_req) |=> (dir_r == $past(mode[0])))
        else $error("direction not taken at data rise");
    a_dead_mutes: assert property ((fb_mode && !sd_s2_r && fb_st_nxt == bswg_pkg::BSWG_FB_DEAD) |=>
        (pins_r.lvl[1] == $past(output_polarity_bits[1])) && (pins_r.lvl[3] == $past(output_polarity_bits[3])))
        else $error("modulated output active during dead band");
    a_dead_ends: assert property ((fb_mode && !rev_req && fb_st_r == bswg_pkg::BSWG_FB_DEAD && db_tick
        && db_cnt_r + 6'h01 == db_tgt_r) |=> (fb_st_r == bswg_pkg::BSWG_FB_RUN))
        else $error("dead band did not end at count");
    a_sleep_no_db: assert property ((fb_mode && !rev_req && !db_clk_select && sleep
        && fb_st_r == bswg_pkg::BSWG_FB_DEAD) |=> (db_cnt_r == $past(db_cnt_r)))
        else $error("dead band advanced on stopped system clock");
    a_async_steer: assert property ((enable && mode == bswg_pkg::MODE_ASYNC_STEER) |=>
        (steer_eff_r == $past(steer_enable_bits)))
        else $error("async steering not immediate");
    a_sync_steer: assert property ((enable && mode == bswg_pkg::MODE_SYNC_STEER && !data_rise) |=>
        (steer_eff_r == $past(steer_eff_r)))
        else $error("sync steering changed between data edges");
    a_ovr_direct: assert property ((enable && mode[2:1] == bswg_pkg::MODE_STEER_HI && !steer_eff_nxt[0]) |=>
        (pins_r.oe[0] && pins_r.lvl[0] == $past(override_level_bits[0])))
        else $error("override level not driven");
    a_steer_sd: assert property ((enable && mode[2:1] == bswg_pkg::MODE_STEER_HI && sd_s2_r && steer_eff_nxt[0]
        && shutdown_level_a_c == bswg_pkg::LVL_LOW) |=> (pins_r.oe[0] && !pins_r.lvl[0]))
        else $error("steered output ignored shutdown");
    // Modulated outputs, dead-band entry and high-z shutdown
    a_fwd_mod_d: assert property ((fb_mode && !sd_s2_r && !dir_r && !rev_req
        && fb_st_r == bswg_pkg::BSWG_FB_RUN)
        |=> (pins_r.lvl[3] == ($past(data_cur) ^ $past(output_polarity_bits[3]))))
        else $error("forward output d does not follow data");
    a_rev_mod_b: assert property ((fb_mode && !sd_s2_r && dir_r && !rev_req
        && fb_st_r == bswg_pkg::BSWG_FB_RUN)
        |=> (pins_r.lvl[1] == ($past(data_cur) ^ $past(output_polarity_bits[1]))))
        else $error("reverse output b does not follow data");
    a_zero_db: assert property ((fb_mode && rev_req
        && ((mode[0] && db_rise_count == 6'h00) || (!mode[0] && db_fall_count == 6'h00)))
        |=> (fb_st_r == bswg_pkg::BSWG_FB_RUN))
        else $error("dead band inserted with zero count");
    a_dead_starts: assert property ((fb_mode && rev_req
        && ((mode[0] && db_rise_count != 6'h00) || (!mode[0] && db_fall_count != 6'h00)))
        |=> (fb_st_r == bswg_pkg::BSWG_FB_DEAD))
        else $error("dead band not started at reversal");
    a_steer_pol: assert property ((enable && mode[2:1] == bswg_pkg::MODE_STEER_HI
        && !sd_s2_r && steer_eff_nxt[1])
        |=> (pins_r.oe[1] && pins_r.lvl[1] == ($past(data_cur) ^ $past(output_polarity_bits[1]))))
        else $error("steered output b not data with polarity");
    a_sd_fb_hiz: assert property ((fb_mode && sd_s2_r && shutdown_level_b_d == bswg_pkg::LVL_HIGHZ) |=>
        (!pins_r.oe[1] && !pins_r.oe[3]))
        else $error("shutdown high-z not applied to b and d");

endmodule

`default_nettype wire

// ===== core/bswg_pkg.sv
// Shared constants and types for the bridge steering waveform generator
package bswg_pkg;

    // ****************************************
    // Mode field encodings
    // ****************************************
    localparam logic [2:0] MODE_ASYNC_STEER = 3'h0;
    localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
    localparam logic [2:0] MODE_FB_FWD = 3'h2;
    localparam logic [2:0] MODE_FB_REV = 3'h3;
    localparam logic [1:0] MODE_FB_HI = 2'h1;   // Mode bits 2:1 of either full-bridge mode
    localparam logic [1:0] MODE_STEER_HI = 2'h0;

    // ****************************************
    // Sizes and output indices
    // ****************************************
    localparam int SRC_NUM = 16;
    localparam int SEL_W = 4;
    localparam int DB_W = 6;
    localparam int OUT_NUM = 4;
    localparam int IDX_A = 0;
    localparam int IDX_B = 1;
    localparam int IDX_C = 2;
    localparam int IDX_D = 3;

    // ****************************************
    // Shutdown level field encodings
    // ****************************************
    localparam logic [1:0] LVL_INACTIVE = 2'h0;
    localparam logic [1:0] LVL_HIGHZ = 2'h1;
    localparam logic [1:0] LVL_LOW = 2'h2;
    localparam logic [1:0] LVL_HIGH = 2'h3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0] PINS_RST = 4'h0;
    localparam logic DIR_RST = 1'b0;
    localparam logic [5:0] CNT_RST = 6'h00;
    localparam logic [15:0] SRC_RST = 16'h0000;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [3:0] lvl;    // Pin level, bit 0 is output a
        logic [3:0] oe;     // High while the pin is driven
    } bswg_pins_t;

    typedef struct packed {
        logic [3:0] steer;  // Steering enables
        logic [3:0] ovr;    // Override levels
        logic [3:0] pol;    // Polarity, set inverts
    } bswg_outcfg_t;

    typedef enum logic [0:0] {
        BSWG_FB_RUN = 1'b0,
        BSWG_FB_DEAD = 1'b1
    } bswg_fb_state_t;

endpackage

// ===== dv/bswg_bridge_drv.sv
// Gate-driver model of the full bridge fed by the four waveform outputs
`timescale 1ns/1ps
`default_nettype none
module bswg_bridge_drv (
    input wire logic [3:0] wave_out,    // Levels from the generator
    input wire logic [3:0] wave_oe,     // High where the pin is driven
    input wire logic [3:0] act_low,     // Drivers that switch on at a low level
    output logic [3:0] gate_on,         // Switch a..d conducting
    output logic shoot                  // Both switches of one leg conducting
);
    // An undriven pin is held off by the driver bias, never by a stale level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            gate_on[i] = wave_oe[i] & (wave_out[i] ^ act_low[i]);
        end
    end
    // Legs are a/b and c/d; both on at once is a short across the supply
    assign shoot = (gate_on[0] & gate_on[1]) | (gate_on[2] & gate_on[3]);
endmodule
`default_nettype wire

// ===== dv/test_bswg_top.sv
// Self-checking bench for the bridge steering waveform generator
`timescale 1ns/1ps
`default_nettype none
module test_bswg_top;
    logic core_clk = 1'b0, rst_n = 1'b0, enable = 1'b0, shutdown_in = 1'b0;
    logic [2:0] mode = 3'h2;
    logic [3:0] sel = 4'h0, steer = 4'h0, ovr = 4'h0, pol = 4'h0, m_steer = 4'h0;
    logic [15:0] src_in = 16'h0000;
    logic [1:0] lvl_bd = 2'h0, lvl_ac = 2'h0;
    logic [5:0] db_r = 6'h00, db_f = 6'h00;
    logic clk_sel = 1'b0, osc = 1'b0, osc_run = 1'b0, sleep = 1'b0;
    logic [3:0] wave_out, wave_oe, gate_on;
    logic direction, shoot;
    int n_fail = 0, checks_done = 0, m_dir = 0, m_dead = 0, m_dat = 0;

    // Clock and a free fast oscillator toggling every cycle
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (osc_run) osc <= ~osc;

    bswg_top bswg_top_inst (.core_clk(core_clk), .rst_n(rst_n), .enable(enable), .mode(mode),
        .data_input_select(sel), .src_in(src_in), .steer_enable_bits(steer), .override_level_bits(ovr),
        .output_polarity_bits(pol), .shutdown_in(shutdown_in), .shutdown_level_b_d(lvl_bd),
        .shutdown_level_a_c(lvl_ac), .db_rise_count(db_r), .db_fall_count(db_f), .db_clk_select(clk_sel),
        .internal_fast_oscillator(osc), .sleep(sleep), .wave_out(wave_out), .wave_oe(wave_oe),
        .direction(direction));
    bswg_bridge_drv bswg_bridge_drv_inst (.wave_out(wave_out), .wave_oe(wave_oe), .act_low(pol),
        .gate_on(gate_on), .shoot(shoot));

    // ****************************************
    // Reference model and checks
    // ****************************************
    // Settled pin image {oe, level}; dead band is flagged by the sequence
    function automatic logic [7:0] exp_pins();
        logic [3:0] lv, oe, act;
        logic [1:0] code;
        lv = 4'h0;
        oe = 4'h0;
        if (enable && !mode[2]) begin
            oe = 4'hf;
            act = (m_dir != 0) ? {1'b0, 1'b1, 1'(m_dat != 0 && m_dead == 0), 1'b0}
                               : {1'(m_dat != 0 && m_dead == 0), 1'b0, 1'b0, 1'b1};
            if (mode[1]) lv = act ^ pol;
            else lv = (m_steer & ({4{m_dat != 0}} ^ pol)) | (~m_steer & ovr);
            for (int i = 0; i < 4; i++) begin
                code = (i % 2 == 1) ? lvl_bd : lvl_ac;
                if (shutdown_in && (mode[1] || m_steer[i])) begin
                    lv[i] = (code == 2'h0) ? pol[i] : code[0];
                    oe[i] = (code != 2'h1);
                end
            end
        end
        return {oe, lv};
    endfunction

    task automatic chk();
        logic [7:0] e;
        @(negedge core_clk);
        e = exp_pins();
        checks_done++;
        if (wave_oe !== e[7:4] || (wave_out & wave_oe) !== (e[3:0] & e[7:4]) || direction !== m_dir[0]
            || (mode[1] && enable && !shutdown_in && shoot !== 1'b0)) begin
            n_fail++;
            $display("unexpected at %0t: oe %h out %h dir %b", $time, wave_oe, wave_out, direction);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Selected source gets d, every other source the opposite
    task automatic drv(input int d);
        cyc(1);
        src_in <= (d != 0) ? (16'h0001 << sel) : ~(16'h0001 << sel);
        m_dat = d;
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #50000;
        n_fail++;
        $display("unexpected at %0t: run did not complete", $time);
        tally_and_finish();
    end

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        void'($urandom(51915));
        cyc(5);
        chk();
        cyc(1);
        rst_n <= 1'b1;
        enable <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            drv(k % 2);
            pol <= 4'($urandom);
            cyc(4);
            chk();
        end
        // Reversal with system-clock dead band
        drv(0);
        pol <= 4'h0;
        db_r <= 6'd12;
        db_f <= 6'd6;
        cyc(4);
        mode <= 3'h3;
        cyc(10);
        chk();
        drv(1);
        m_dir = 1;
        m_dead = 1;
        cyc(12);
        chk();
        m_dead = 0;
        cyc(8);
        chk();
        // Forward again, oscillator ticks, asleep
        drv(0);
        clk_sel <= 1'b1;
        osc_run <= 1'b1;
        sleep <= 1'b1;
        cyc(4);
        mode <= 3'h2;
        drv(1);
        m_dir = 0;
        m_dead = 1;
        cyc(10);
        chk();
        m_dead = 0;
        cyc(14);
        chk();
        // System clock asleep: dead band must not expire
        drv(0);
        clk_sel <= 1'b0;
        cyc(4);
        mode <= 3'h3;
        drv(1);
        m_dir = 1;
        m_dead = 1;
        cyc(40);
        chk();
        cyc(1);
        sleep <= 1'b0;
        m_dead = 0;
        cyc(16);
        chk();
        // Back to forward with a zero count: no dead band at all
        drv(0);
        db_f <= 6'h00;
        cyc(4);
        mode <= 3'h2;
        drv(1);
        m_dir = 0;
        cyc(4);
        chk();
        for (int k = 0; k < 4; k++) begin
            cyc(1);
            shutdown_in <= 1'b1;
            lvl_ac <= 2'(k);
            lvl_bd <= 2'(3 - k);
            pol <= 4'($urandom);
            cyc(5);
            chk();
        end
        // Asynchronous steering, mode changed only while disabled
        cyc(1);
        enable <= 1'b0;
        shutdown_in <= 1'b0;
        lvl_ac <= 2'h2;
        cyc(1);
        mode <= 3'h0;
        m_dir = 0;
        cyc(1);
        enable <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            cyc(1);
            shutdown_in <= k[2];
            drv(k % 2);
            cyc(4);
            steer <= 4'($urandom) | 4'(k == 5);
            ovr <= 4'($urandom);
            pol <= 4'($urandom);
            cyc(1);
            m_steer = steer;
            chk();
        end
        // Synchronous steering
        cyc(1);
        enable <= 1'b0;
        shutdown_in <= 1'b0;
        cyc(1);
        mode <= 3'h1;
        steer <= 4'h5;
        m_dir = 1;
        cyc(1);
        enable <= 1'b1;
        drv(0);
        cyc(4);
        drv(1);
        cyc(4);
        m_steer = 4'h5;
        chk();
        cyc(1);
        steer <= 4'ha;
        cyc(6);
        chk();
        cyc(1);
        ovr <= ~ovr;
        cyc(1);
        chk();
        drv(0);
        cyc(4);
        drv(1);
        m_steer = 4'ha;
        cyc(4);
        chk();
        // Every data source in turn
        cyc(1);
        enable <= 1'b0;
        cyc(1);
        mode <= 3'h0;
        steer <= 4'hf;
        pol <= 4'h0;
        m_steer = 4'hf;
        m_dir = 0;
        cyc(1);
        enable <= 1'b1;
        for (int s = 0; s < 16; s++) begin
            cyc(1);
            sel <= 4'(s);
            drv(1);
            cyc(5);
            chk();
            drv(0);
            cyc(4);
            chk();
        end
        // Unsupported mode code leaves every pin undriven
        cyc(1);
        enable <= 1'b0;
        cyc(1);
        mode <= 3'h4;
        cyc(1);
        enable <= 1'b1;
        cyc(2);
        chk();
        tally_and_finish();
    end
endmodule
`default_nettype wire
